// ==== uus_defs.svh ====
`ifndef UUS_DEFS_SVH
`define UUS_DEFS_SVH
`define UUS_POS_DEN_ADDR 16'h060e
`define UUS_POS_NUM_ADDR 16'h0610
`define UUS_VEL_DEN_ADDR 16'h0642
`define UUS_VEL_NUM_ADDR 16'h0644
`define UUS_RAMP_DEN_ADDR 16'h0660
`define UUS_RAMP_NUM_ADDR 16'h0662
`define UUS_POS_DEN_RST 32'h00004000
`define UUS_POS_NUM_RST 32'h00000001
`define UUS_VEL_DEN_RST 32'h00000001
`define UUS_VEL_NUM_RST 32'h00000001
`define UUS_RAMP_DEN_RST 32'h00000001
`define UUS_RAMP_NUM_RST 32'h00000001
`define UUS_RATIO_MIN 32'h00000001
`define UUS_RATIO_MAX 32'h7fffffff
`define UUS_JOG_POS_MIN 32'hf0000000
`define UUS_JOG_POS_MAX 32'h0fffffff
`define UUS_DIV_STEPS 7'h40
`define UUS_RES_POS_MAX 64'h000000007fffffff
`define UUS_RES_NEG_MAX 64'h0000000080000000
`define UUS_SAT_POS 32'h7fffffff
`define UUS_SAT_NEG 32'h80000000
`endif

// ==== uus_pkg.sv ====
package uus_pkg;
  typedef enum logic [1:0] {
    UUS_Q_POS,
    UUS_Q_VEL,
    UUS_Q_RAMP,
    UUS_Q_NONE
  } uus_qty_type;
  typedef enum logic [1:0] {
    UUS_ST_IDLE,
    UUS_ST_MUL,
    UUS_ST_DIV,
    UUS_ST_DONE
  } uus_state_type;
endpackage : uus_pkg

// ==== uus_scaler.sv ====
`timescale 1ns/1ps
`include "uus_defs.svh"

module uus_scaler #(
  parameter int PADDR_W = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [PADDR_W-1:0] param_addr_in,
  input wire logic param_wr_in,
  input wire logic param_rd_in,
  input wire logic [31:0] param_wdata_in,
  output logic [31:0] param_rdata_out,
  output logic param_ack_out,
  output logic param_err_out,
  input wire logic power_stage_on_in,
  input wire logic jog_mode_in,
  input wire logic conv_start_in,
  input wire logic [1:0] conv_sel_in,
  input wire logic conv_to_user_in,
  input wire logic [31:0] conv_value_in,
  output logic conv_busy_out,
  output logic conv_done_out,
  output logic [31:0] conv_result_out,
  output logic conv_err_out
);

  localparam logic [31:0] NUM_RST [3] = '{
    `UUS_POS_NUM_RST,
    `UUS_VEL_NUM_RST,
    `UUS_RAMP_NUM_RST
  };
  localparam logic [31:0] DEN_RST [3] = '{
    `UUS_POS_DEN_RST,
    `UUS_VEL_DEN_RST,
    `UUS_RAMP_DEN_RST
  };

  function automatic logic [31:0] clamp_pos(input logic [31:0] v);
    if ($signed(v) < $signed(`UUS_JOG_POS_MIN))
    begin
      return `UUS_JOG_POS_MIN;
    end
    else if ($signed(v) > $signed(`UUS_JOG_POS_MAX))
    begin
      return `UUS_JOG_POS_MAX;
    end
    return v;
  endfunction : clamp_pos

  // Two's complement negation shared by magnitude and sign restore
  function automatic logic [31:0] neg32(input logic [31:0] v);
    return ~v + 32'h00000001;
  endfunction : neg32

  function automatic logic [31:0] mag32(input logic [31:0] v);
    return v[31] ? neg32(v) : v;
  endfunction : mag32

  // Select code 3 carries no ratio; a ratio of one keeps the engine harmless
  function automatic logic [31:0] pick3(input logic [1:0] s, input logic [31:0] w0,
    input logic [31:0] w1, input logic [31:0] w2);
    if (s == 2'h0)
    begin
      return w0;
    end
    else if (s == 2'h1)
    begin
      return w1;
    end
    else if (s == 2'h2)
    begin
      return w2;
    end
    return 32'h00000001;
  endfunction : pick3

  // Ratio storage
  logic [31:0] num_q [3];
  logic [31:0] pend_q [3];
  logic [31:0] act_den_q [3];

  // Address decode
  logic [2:0] hit_num;
  logic [2:0] hit_den;
  logic mapped;
  logic val_ok;
  logic wr_ok;
  logic wr_bad;
  logic [31:0] rd_mux;

  assign hit_num[0] = param_addr_in == PADDR_W'(`UUS_POS_NUM_ADDR);
  assign hit_num[1] = param_addr_in == PADDR_W'(`UUS_VEL_NUM_ADDR);
  assign hit_num[2] = param_addr_in == PADDR_W'(`UUS_RAMP_NUM_ADDR);
  assign hit_den[0] = param_addr_in == PADDR_W'(`UUS_POS_DEN_ADDR);
  assign hit_den[1] = param_addr_in == PADDR_W'(`UUS_VEL_DEN_ADDR);
  assign hit_den[2] = param_addr_in == PADDR_W'(`UUS_RAMP_DEN_ADDR);
  assign mapped = |{hit_num, hit_den};

  // Signed compare covers both ends of the legal range
  assign val_ok = ($signed(param_wdata_in) >= $signed(`UUS_RATIO_MIN)) &&
                  ($signed(param_wdata_in) <= $signed(`UUS_RATIO_MAX));

  // Refused writes leave every ratio untouched
  assign wr_ok = param_wr_in && mapped && val_ok && !power_stage_on_in;
  assign wr_bad = param_wr_in && !wr_ok;

  // Numerators read back active value, denominators the last written one
  assign rd_mux = hit_num[0] ? num_q[0] :
                  hit_num[1] ? num_q[1] :
                  hit_num[2] ? num_q[2] :
                  hit_den[0] ? pend_q[0] :
                  hit_den[1] ? pend_q[1] :
                  hit_den[2] ? pend_q[2] : 32'h00000000;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 3; i++)
      begin
        num_q[i] <= NUM_RST[i];
        pend_q[i] <= DEN_RST[i];
        act_den_q[i] <= DEN_RST[i];
      end
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wr_ok && hit_den[i])
        begin
          pend_q[i] <= param_wdata_in;
        end
        if (wr_ok && hit_num[i])
        begin
          num_q[i] <= param_wdata_in;
          act_den_q[i] <= pend_q[i];
        end
      end
    end
  end

  // Bus answer, one cycle after the request
  logic [31:0] rdata_q;
  logic ack_q;
  logic err_q;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      ack_q <= param_wr_in || param_rd_in;
      err_q <= wr_bad || (param_rd_in && !param_wr_in && !mapped);
      if (param_rd_in && !param_wr_in)
      begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign param_rdata_out = rdata_q;
  assign param_ack_out = ack_q;
  assign param_err_out = err_q;

  // Conversion engine
  uus_pkg::uus_state_type state_q;
  uus_pkg::uus_qty_type sel;
  logic sel_ok;
  logic is_pos_q;
  logic to_user_q;
  logic neg_q;
  logic bad_q;
  logic [31:0] val_q;
  logic [31:0] mul_q;
  logic [31:0] div_q;
  logic [63:0] quot_q;
  logic [32:0] rem_q;
  logic [6:0] cnt_q;
  logic [31:0] in_val;
  logic [31:0] pick_num;
  logic [31:0] pick_den;
  logic [32:0] rem_sh;
  logic rem_ge;
  logic sat;
  logic [31:0] raw_res;
  logic [31:0] fin_res;
  logic [31:0] result_q;
  logic done_q;
  logic cerr_q;

  assign sel = uus_pkg::uus_qty_type'(conv_sel_in);
  assign sel_ok = sel != uus_pkg::UUS_Q_NONE;
  assign pick_num = pick3(conv_sel_in, num_q[0], num_q[1], num_q[2]);
  assign pick_den = pick3(conv_sel_in, act_den_q[0], act_den_q[1], act_den_q[2]);

  // User-side positions are bounded on entry in jog only
  assign in_val = (sel == uus_pkg::UUS_Q_POS && jog_mode_in && !conv_to_user_in) ?
                  clamp_pos(conv_value_in) : conv_value_in;

  // Restoring division step over the magnitude product
  assign rem_sh = {rem_q[31:0], quot_q[63]};
  assign rem_ge = rem_sh >= {1'b0, div_q};

  // Overflow saturates and raises the error rather than wrapping
  assign sat = neg_q ? (quot_q > `UUS_RES_NEG_MAX) : (quot_q > `UUS_RES_POS_MAX);
  assign raw_res = sat ? (neg_q ? `UUS_SAT_NEG : `UUS_SAT_POS) :
                   (neg_q ? neg32(quot_q[31:0]) : quot_q[31:0]);
  assign fin_res = (is_pos_q && jog_mode_in && to_user_q) ?
                   clamp_pos(raw_res) : raw_res;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= uus_pkg::UUS_ST_IDLE;
      is_pos_q <= 1'b0;
      to_user_q <= 1'b0;
      neg_q <= 1'b0;
      bad_q <= 1'b0;
      val_q <= 32'h00000000;
      mul_q <= 32'h00000000;
      div_q <= 32'h00000001;
      quot_q <= 64'h0000000000000000;
      rem_q <= 33'h000000000;
      cnt_q <= 7'h00;
      result_q <= 32'h00000000;
      done_q <= 1'b0;
      cerr_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      unique case (state_q)
        uus_pkg::UUS_ST_IDLE:
        begin
          if (conv_start_in)
          begin
            // Ratio is sampled here so a later write cannot tear a result
            is_pos_q <= sel == uus_pkg::UUS_Q_POS;
            to_user_q <= conv_to_user_in;
            bad_q <= !sel_ok;
            val_q <= in_val;
            mul_q <= conv_to_user_in ? pick_den : pick_num;
            div_q <= conv_to_user_in ? pick_num : pick_den;
            state_q <= uus_pkg::UUS_ST_MUL;
          end
        end
        uus_pkg::UUS_ST_MUL:
        begin
          neg_q <= val_q[31];
          quot_q <= {32'h00000000, mag32(val_q)} * {32'h00000000, mul_q};
          rem_q <= 33'h000000000;
          cnt_q <= `UUS_DIV_STEPS;
          state_q <= uus_pkg::UUS_ST_DIV;
        end
        uus_pkg::UUS_ST_DIV:
        begin
          // Magnitude division truncates toward zero for either sign
          rem_q <= rem_ge ? (rem_sh - {1'b0, div_q}) : rem_sh;
          quot_q <= {quot_q[62:0], rem_ge};
          cnt_q <= cnt_q - 7'h01;
          if (cnt_q == 7'h01)
          begin
            state_q <= uus_pkg::UUS_ST_DONE;
          end
        end
        uus_pkg::UUS_ST_DONE:
        begin
          result_q <= bad_q ? 32'h00000000 : fin_res;
          cerr_q <= bad_q || sat;
          done_q <= 1'b1;
          state_q <= uus_pkg::UUS_ST_IDLE;
        end
      endcase
    end
  end

  assign conv_busy_out = state_q != uus_pkg::UUS_ST_IDLE;
  assign conv_done_out = done_q;
  assign conv_result_out = result_q;
  assign conv_err_out = cerr_q;

endmodule : uus_scaler

// ==== uus_scaler_monitor.sv ====
`timescale 1ns/1ps
module uus_scaler_monitor (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic param_wr_in,
  input wire logic param_rd_in,
  input wire logic [31:0] param_wdata_in,
  input wire logic param_ack_out,
  input wire logic param_err_out,
  input wire logic power_stage_on_in,
  input wire logic conv_start_in,
  input wire logic [1:0] conv_sel_in,
  input wire logic conv_busy_out,
  input wire logic conv_done_out,
  input wire logic [31:0] conv_result_out,
  input wire logic conv_err_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  wire req = param_wr_in || param_rd_in;
  wire go = conv_start_in && !conv_busy_out;
  property p_ack;
    req |=> param_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("request not acknowledged");
  property p_idle;
    !req |=> !param_ack_out && !param_err_out;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_pwr;
    param_wr_in && power_stage_on_in |=> param_err_out;
  endproperty
  a_pwr: assert property (p_pwr) else $error("write taken with power on");
  property p_low;
    param_wr_in && $signed(param_wdata_in) < 1 |=> param_err_out;
  endproperty
  a_low: assert property (p_low) else $error("ratio below one taken");
  property p_lat;
    go |-> ##67 conv_done_out;
  endproperty
  a_lat: assert property (p_lat) else $error("conversion late or early");
  property p_busy;
    go |=> conv_busy_out [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped early");
  property p_ill;
    go && conv_sel_in == 2'h3 |-> ##67 conv_err_out && conv_result_out == 32'h0;
  endproperty
  a_ill: assert property (p_ill) else $error("illegal select not flagged");
  property p_pulse;
    conv_done_out |=> !conv_done_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done longer than a cycle");
  cover property (param_wr_in && power_stage_on_in);
  cover property (conv_done_out && !conv_err_out);
  cover property (param_rd_in ##1 param_ack_out);
endmodule : uus_scaler_monitor
bind uus_scaler uus_scaler_monitor mon (.core_clk_in, .rst_in, .param_wr_in, .param_rd_in,
  .param_wdata_in, .param_ack_out, .param_err_out, .power_stage_on_in, .conv_start_in,
  .conv_sel_in, .conv_busy_out, .conv_done_out, .conv_result_out, .conv_err_out);

// ==== uus_host.sv ====
`timescale 1ns/1ps
module uus_host (
  input wire logic core_clk_in,
  input wire logic param_ack_in,
  input wire logic param_err_in,
  input wire logic [31:0] param_rdata_in,
  output logic [15:0] param_addr_out = 16'h0,
  output logic param_wr_out = 1'b0,
  output logic param_rd_out = 1'b0,
  output logic [31:0] param_wdata_out = 32'h0
);
  // Ratios go out as whole signed 32-bit words
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(negedge core_clk_in);
    param_wr_out = w;
    param_rd_out = !w;
    param_addr_out = a;
    param_wdata_out = d;
    @(negedge core_clk_in);
    param_wr_out = 1'b0;
    param_rd_out = 1'b0;
    // Inverted leftovers so a stale bus value cannot pass
    param_addr_out = ~a;
    param_wdata_out = ~d;
    q = param_rdata_in;
    e = (param_ack_in === 1'b1) ? param_err_in : 1'bx;
  endtask : xfer
endmodule : uus_host

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic core_clk_in = 1'b0, rst_in = 1'b1, power_stage_on_in = 1'b0, jog_mode_in = 1'b0;
  logic conv_start_in = 1'b0, conv_to_user_in = 1'b0, param_wr_in, param_rd_in, e;
  logic param_ack_out, param_err_out, conv_busy_out, conv_done_out, conv_err_out;
  logic [1:0] conv_sel_in = 2'h0;
  logic [15:0] param_addr_in;
  logic [31:0] param_wdata_in, param_rdata_out, conv_result_out, q, conv_value_in = 32'h0;
  int miscompares = 0, checks = 0, cycles = 0;
  uus_scaler dut (.core_clk_in, .rst_in, .param_addr_in, .param_wr_in, .param_rd_in,
    .param_wdata_in, .param_rdata_out, .param_ack_out, .param_err_out, .power_stage_on_in,
    .jog_mode_in, .conv_start_in, .conv_sel_in, .conv_to_user_in, .conv_value_in,
    .conv_busy_out, .conv_done_out, .conv_result_out, .conv_err_out);
  uus_host host (.core_clk_in, .param_ack_in(param_ack_out), .param_err_in(param_err_out),
    .param_rdata_in(param_rdata_out), .param_addr_out(param_addr_in),
    .param_wr_out(param_wr_in), .param_rd_out(param_rd_in), .param_wdata_out(param_wdata_in));
  initial forever #2.5 core_clk_in = ~core_clk_in;
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // Whole run needs about 1200 cycles
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic ee);
    host.xfer(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, ee});
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic ee);
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask : rd
  task automatic cv(input logic [1:0] s, input logic u, input logic [31:0] v, exp,
    input logic ee);
    @(negedge core_clk_in);
    conv_sel_in = s;
    conv_to_user_in = u;
    conv_value_in = v;
    conv_start_in = 1'b1;
    @(negedge core_clk_in);
    conv_start_in = 1'b0;
    conv_value_in = ~v;
    chk({31'h0, conv_busy_out}, 32'h1);
    for (int i = 0; i < 80 && conv_done_out !== 1'b1; i++) @(negedge core_clk_in);
    chk({31'h0, conv_done_out}, 32'h1);
    chk(conv_result_out, exp);
    chk({31'h0, conv_err_out}, {31'h0, ee});
  endtask : cv
  initial
  begin
    repeat (8) @(negedge core_clk_in);
    rst_in = 1'b0;
    rd(16'h060e, 32'h4000, 0);
    rd(16'h0610, 32'h1, 0);
    rd(16'h0642, 32'h1, 0);
    rd(16'h0644, 32'h1, 0);
    rd(16'h0660, 32'h1, 0);
    rd(16'h0662, 32'h1, 0);
    cv(0, 0, 32'h4000, 32'h1, 0);
    cv(0, 0, 32'hffffc001, 32'h0, 0);
    cv(0, 1, 32'h3, 32'hc000, 0);
    cv(0, 0, 32'h7fffffff, 32'h1ffff, 0);
    cv(0, 1, 32'h7fffffff, 32'h7fffffff, 1);
    jog_mode_in = 1'b1;
    cv(0, 1, 32'h4000, 32'h0fffffff, 0);
    cv(0, 1, 32'hffffbfff, 32'hf0000000, 0);
    cv(0, 0, 32'h7fffffff, 32'h3fff, 0);
    cv(0, 0, 32'h80000000, 32'hffffc000, 0);
    jog_mode_in = 1'b0;
    wr(16'h060e, 32'h3, 0);
    cv(0, 0, 32'h4000, 32'h1, 0);
    rd(16'h060e, 32'h3, 0);
    wr(16'h0610, 32'h2, 0);
    cv(0, 0, 32'h9, 32'h6, 0);
    cv(0, 1, 32'h6, 32'h9, 0);
    wr(16'h0642, 32'h4, 0);
    cv(1, 0, 32'h8, 32'h8, 0);
    wr(16'h0644, 32'h1, 0);
    cv(1, 0, 32'h8, 32'h2, 0);
    wr(16'h0660, 32'h5, 0);
    cv(2, 0, 32'ha, 32'ha, 0);
    wr(16'h0662, 32'h2, 0);
    cv(2, 0, 32'ha, 32'h4, 0);
    power_stage_on_in = 1'b1;
    wr(16'h0610, 32'h7, 1);
    rd(16'h0610, 32'h2, 0);
    power_stage_on_in = 1'b0;
    wr(16'h0642, 32'h0, 1);
    wr(16'h0642, 32'h80000000, 1);
    wr(16'h0642, 32'h7fffffff, 0);
    rd(16'h0642, 32'h7fffffff, 0);
    rd(16'h0600, 32'h0, 1);
    wr(16'h0600, 32'h5, 1);
    cv(3, 0, 32'h5, 32'h0, 1);
    rst_in = 1'b1;
    @(negedge core_clk_in);
    rst_in = 1'b0;
    rd(16'h0610, 32'h1, 0);
    end_of_test();
  end
endmodule : testbench
